// ---- design/ofs_pkg.sv ----
package ofs_pkg;

	// ==========================================================
	// timing
	localparam int unsigned CLK_FREQ_HZ = 200_000_000;
	localparam int unsigned PWM_FREQ_HZ = 125;
	localparam int unsigned PWM_PERIOD_CYCLES = CLK_FREQ_HZ / PWM_FREQ_HZ;
	localparam int unsigned PWM_CNT_W = 21;

	// ==========================================================
	// selection codes
	localparam logic [3:0] SEL_LBD_ON = 4'h0;
	localparam logic [3:0] SEL_LBD_OFF = 4'h1;
	localparam logic [3:0] SEL_GEN_ON = 4'h2;
	localparam logic [3:0] SEL_GEN_OFF = 4'h3;
	localparam logic [3:0] SEL_EVT_ON = 4'h4;
	localparam logic [3:0] SEL_EVT_OFF = 4'h5;
	localparam logic [3:0] SEL_BAT2_ON = 4'h6;
	localparam logic [3:0] SEL_BAT2_OFF = 4'h7;
	localparam logic [3:0] SEL_ALARM_OFF = 4'h8;
	localparam logic [3:0] SEL_ALARM_ON = 4'h9;
	localparam logic [3:0] SEL_SHUNT = 4'ha;
	localparam logic [3:0] SEL_SHUNT_INV = 4'hb;

	// ==========================================================
	// reset values
	localparam logic [3:0] LOAD_SEL_RST = SEL_LBD_OFF;
	localparam logic [3:0] AUX_SEL_RST = SEL_GEN_ON;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic lbd_disconnect;
		logic gen_run;
		logic event_on;
		logic batt2_charge;
		logic below_alarm;
		logic shunt_disconnect;
	} ofs_func_type;

	typedef struct packed {
		logic [3:0] load;
		logic [3:0] aux;
	} ofs_sel_type;

	typedef struct packed {
		logic load_out;
		logic aux_out;
		logic load_indicator;
		logic generator_indicator;
		logic solar_input_switch;
	} ofs_out_type;

endpackage : ofs_pkg

// ---- design/ofs_pwm_gen.sv ----
`timescale 1ns/1ps
`default_nettype none

module ofs_pwm_gen #(
	parameter int unsigned N_CH = 2,
	parameter int unsigned CNT_W = ofs_pkg::PWM_CNT_W,
	parameter int unsigned PERIOD = ofs_pkg::PWM_PERIOD_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [N_CH-1:0][CNT_W-1:0] duty,
	output logic [N_CH-1:0] wave
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic run;
	} ofs_pwm_state_type;

	localparam logic [CNT_W-1:0] LAST = CNT_W'(PERIOD - 1);

	ofs_pwm_state_type st_q;
	ofs_pwm_state_type st_d;

	always_comb begin
		st_d = st_q;
		st_d.run = 1'b1;
		if (st_q.cnt == LAST) begin
			st_d.cnt = '0;
		end else begin
			st_d.cnt = st_q.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// per-channel compare
	genvar g;
	generate
		for (g = 0; g < N_CH; g++) begin : g_ch
			assign wave[g] = st_q.cnt < duty[g];
		end
	endgenerate

	// ==========================================================
	// checks
	property p_pwm_wrap;
		@(posedge ref_clk) disable iff (!reset_n)
		(st_q.run && st_q.cnt == LAST) |=> (st_q.cnt == '0);
	endproperty
	a_pwm_wrap: assert property (p_pwm_wrap)
		else $error("pwm counter did not wrap at period end");

	property p_pwm_bound;
		@(posedge ref_clk) disable iff (!reset_n)
		st_q.cnt <= LAST;
	endproperty
	a_pwm_bound: assert property (p_pwm_bound)
		else $error("pwm counter beyond period");

endmodule : ofs_pwm_gen

`default_nettype wire

// ---- design/ofs_func_mux.sv ----
`timescale 1ns/1ps
`default_nettype none

module ofs_func_mux #(
	parameter bit PWM_CAPABLE = 1'b0
) (
	input wire logic [3:0] sel,
	input wire ofs_pkg::ofs_func_type func,
	input wire logic pwm_en,
	input wire logic pwm_wave,
	output logic level
);

	always_comb begin
		case (sel)
			ofs_pkg::SEL_LBD_ON: level = func.lbd_disconnect;
			ofs_pkg::SEL_LBD_OFF: level = !func.lbd_disconnect;
			ofs_pkg::SEL_GEN_ON: level = func.gen_run;
			ofs_pkg::SEL_GEN_OFF: level = !func.gen_run;
			ofs_pkg::SEL_EVT_ON: level = func.event_on;
			ofs_pkg::SEL_EVT_OFF: level = !func.event_on;
			ofs_pkg::SEL_BAT2_ON: level = func.batt2_charge;
			ofs_pkg::SEL_BAT2_OFF: level = !func.batt2_charge;
			ofs_pkg::SEL_ALARM_OFF: level = !func.below_alarm;
			ofs_pkg::SEL_ALARM_ON: level = func.below_alarm;
			ofs_pkg::SEL_SHUNT: begin
				// dump load on for regulation, chopped when pwm allowed
				if (PWM_CAPABLE && pwm_en) begin
					level = !func.shunt_disconnect && pwm_wave;
				end else begin
					level = !func.shunt_disconnect;
				end
			end
			ofs_pkg::SEL_SHUNT_INV: level = func.shunt_disconnect;
			default: level = 1'b0;
		endcase
	end

endmodule : ofs_func_mux

`default_nettype wire

// ---- design/ofs_output_selector.sv ----
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Two outputs, load and aux, each pick one of six functions by code.
// - Code 0 follows disconnect request, code 1 inverts; load resets to 1.
// - Code 2 follows generator request, code 3 inverts; aux resets to 2.
// - Code 4 follows the programmed event, code 5 inverts it.
// - Code 6 follows second battery charge request, code 7 inverts it.
// - Code 8 is off below alarm voltage, code 9 is on below it.
// - Code 10 drives dump load on for regulation; code 11 inverts.
// - The aux output is never pulse-width modulated, only switched statically.
// - Load indicator lights whenever the low battery disconnect is active.
// - Generator indicator lights whenever the generator is requested.
// - Solar series switching and shunt output work at once, independently.
// - Shunt mode absorbs surplus in dump load, source stays connected.
// - PWM outputs switch once every PWM_PERIOD cycles, which is 125 Hz at the default PWM_PERIOD.
module ofs_output_selector #(
	parameter int unsigned CNT_W = ofs_pkg::PWM_CNT_W,
	parameter int unsigned PWM_PERIOD = ofs_pkg::PWM_PERIOD_CYCLES
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [3:0] load_output_select,
	input wire logic load_select_wr,
	input wire logic [3:0] aux_output_select,
	input wire logic aux_select_wr,
	input wire ofs_pkg::ofs_func_type func_i,
	input wire logic series_charge_on,
	input wire logic pwm_solar_en,
	input wire logic pwm_load_en,
	input wire logic [CNT_W-1:0] solar_duty,
	input wire logic [CNT_W-1:0] shunt_duty,
	output ofs_pkg::ofs_sel_type sel_o,
	output ofs_pkg::ofs_out_type out_o
);

	// ==========================================================
	// state
	typedef struct packed {
		ofs_pkg::ofs_sel_type sel;
		ofs_pkg::ofs_out_type out;
		logic run;
	} ofs_state_type;

	ofs_state_type st_q;
	ofs_state_type st_d;

	logic [1:0] pwm_wave;
	logic [1:0][CNT_W-1:0] pwm_duty;
	logic load_level;
	logic aux_level;
	ofs_pkg::ofs_sel_type sel_nx;

	// ==========================================================
	// pwm source: channel 0 solar, channel 1 load shunt
	assign pwm_duty[0] = solar_duty;
	assign pwm_duty[1] = shunt_duty;

	// next selector, kept apart from the state copy so routing has no loop
	assign sel_nx.load = load_select_wr ? load_output_select
		: st_q.sel.load;
	assign sel_nx.aux = aux_select_wr ? aux_output_select
		: st_q.sel.aux;

	ofs_pwm_gen #(
		.N_CH(2),
		.CNT_W(CNT_W),
		.PERIOD(PWM_PERIOD)
	) u_pwm (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.duty(pwm_duty),
		.wave(pwm_wave)
	);

	// ==========================================================
	// routing, decoded from the selector's next value
	ofs_func_mux #(
		.PWM_CAPABLE(1'b1)
	) u_load_mux (
		.sel(sel_nx.load),
		.func(func_i),
		.pwm_en(pwm_load_en),
		.pwm_wave(pwm_wave[1]),
		.level(load_level)
	);

	ofs_func_mux #(
		.PWM_CAPABLE(1'b0)
	) u_aux_mux (
		.sel(sel_nx.aux),
		.func(func_i),
		.pwm_en(1'b0),
		.pwm_wave(1'b0),
		.level(aux_level)
	);

	always_comb begin
		st_d = st_q;
		st_d.run = 1'b1;
		st_d.sel = sel_nx;
		st_d.out.load_out = load_level;
		st_d.out.aux_out = aux_level;
		st_d.out.load_indicator = func_i.lbd_disconnect;
		st_d.out.generator_indicator = func_i.gen_run;
		// series switch runs alongside the shunt output
		if (pwm_solar_en) begin
			st_d.out.solar_input_switch = series_charge_on && pwm_wave[0];
		end else begin
			st_d.out.solar_input_switch = series_charge_on;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			st_q <= '0;
			st_q.sel.load <= ofs_pkg::LOAD_SEL_RST;
			st_q.sel.aux <= ofs_pkg::AUX_SEL_RST;
		end else begin
			st_q <= st_d;
		end
	end

	assign sel_o = st_q.sel;
	assign out_o = st_q.out;

	// ==========================================================
	// checks
	property p_reset_defaults;
		@(posedge ref_clk)
		$past(!reset_n) |-> (st_q.sel.load == ofs_pkg::LOAD_SEL_RST
			&& st_q.sel.aux == ofs_pkg::AUX_SEL_RST);
	endproperty
	a_reset_defaults: assert property (p_reset_defaults)
		else $error("selector reset defaults wrong");

	property p_load_lbd;
		@(posedge ref_clk) disable iff (!reset_n)
		(st_q.run && st_q.sel.load == 4'h0)
			|-> (out_o.load_out == $past(func_i.lbd_disconnect));
	endproperty
	a_load_lbd: assert property (p_load_lbd)
		else $error("load output does not follow disconnect request");

	property p_aux_gen_inv;
		@(posedge ref_clk) disable iff (!reset_n)
		(st_q.run && st_q.sel.aux == 4'h3)
			|-> (out_o.aux_out == !$past(func_i.gen_run));
	endproperty
	a_aux_gen_inv: assert property (p_aux_gen_inv)
		else $error("aux output not inverse of generator request");

	property p_event_inv;
		@(posedge ref_clk) disable iff (!reset_n)
		(load_select_wr && load_output_select == 4'h5 && func_i.event_on)
			|=> !out_o.load_out;
	endproperty
	a_event_inv: assert property (p_event_inv)
		else $error("load output on while event active with code 5");

	property p_bat2;
		@(posedge ref_clk) disable iff (!reset_n)
		(st_q.run && st_q.sel.aux == 4'h6)
			|-> (out_o.aux_out == $past(func_i.batt2_charge));
	endproperty
	a_bat2: assert property (p_bat2)
		else $error("aux output does not follow second battery charge");

	property p_alarm;
		@(posedge ref_clk) disable iff (!reset_n)
		(st_q.run && st_q.sel.load == 4'h8)
			|-> (out_o.load_out == !$past(func_i.below_alarm));
	endproperty
	a_alarm: assert property (p_alarm)
		else $error("code 8 output not off below alarm");

	property p_shunt_inv;
		@(posedge ref_clk) disable iff (!reset_n)
		(st_q.run && st_q.sel.load == 4'hb)
			|-> (out_o.load_out == $past(func_i.shunt_disconnect));
	endproperty
	a_shunt_inv: assert property (p_shunt_inv)
		else $error("code 11 load output wrong polarity");

	property p_shunt_regulate;
		@(posedge ref_clk) disable iff (!reset_n)
		(st_d.sel.load == 4'ha && !pwm_load_en && !func_i.shunt_disconnect)
			|=> out_o.load_out;
	endproperty
	a_shunt_regulate: assert property (p_shunt_regulate)
		else $error("dump load not connected for regulation");

	property p_aux_static;
		@(posedge ref_clk) disable iff (!reset_n)
		(st_q.run && st_q.sel.aux == 4'ha)
			|-> (out_o.aux_out == !$past(func_i.shunt_disconnect));
	endproperty
	a_aux_static: assert property (p_aux_static)
		else $error("aux shunt output not static");

	property p_load_ind;
		@(posedge ref_clk) disable iff (!reset_n)
		func_i.lbd_disconnect |=> out_o.load_indicator;
	endproperty
	a_load_ind: assert property (p_load_ind)
		else $error("load indicator not lit during disconnect");

	property p_gen_ind;
		@(posedge ref_clk) disable iff (!reset_n)
		st_q.run |-> (out_o.generator_indicator == $past(func_i.gen_run));
	endproperty
	a_gen_ind: assert property (p_gen_ind)
		else $error("generator indicator does not track request");

	property p_solar_indep;
		@(posedge ref_clk) disable iff (!reset_n)
		(!pwm_solar_en) |=> (out_o.solar_input_switch == $past(series_charge_on));
	endproperty
	a_solar_indep: assert property (p_solar_indep)
		else $error("solar switch not following series control");

	property p_load_lbd_inv;
		@(posedge ref_clk) disable iff (!reset_n)
		(st_q.run && st_q.sel.load == ofs_pkg::SEL_LBD_OFF)
			|-> (out_o.load_out == !$past(func_i.lbd_disconnect));
	endproperty
	a_load_lbd_inv: assert property (p_load_lbd_inv)
		else $error("code 1 load output not inverse of disconnect");

	property p_aux_gen;
		@(posedge ref_clk) disable iff (!reset_n)
		(st_q.run && st_q.sel.aux == ofs_pkg::SEL_GEN_ON)
			|-> (out_o.aux_out == $past(func_i.gen_run));
	endproperty
	a_aux_gen: assert property (p_aux_gen)
		else $error("aux output does not follow generator request");

	property p_load_event;
		@(posedge ref_clk) disable iff (!reset_n)
		(st_q.run && st_q.sel.load == ofs_pkg::SEL_EVT_ON)
			|-> (out_o.load_out == $past(func_i.event_on));
	endproperty
	a_load_event: assert property (p_load_event)
		else $error("code 4 load output does not follow event");

	property p_aux_event_inv;
		@(posedge ref_clk) disable iff (!reset_n)
		(st_q.run && st_q.sel.aux == ofs_pkg::SEL_EVT_OFF)
			|-> (out_o.aux_out == !$past(func_i.event_on));
	endproperty
	a_aux_event_inv: assert property (p_aux_event_inv)
		else $error("code 5 aux output not inverse of event");

	property p_load_bat2_inv;
		@(posedge ref_clk) disable iff (!reset_n)
		(st_q.run && st_q.sel.load == ofs_pkg::SEL_BAT2_OFF)
			|-> (out_o.load_out == !$past(func_i.batt2_charge));
	endproperty
	a_load_bat2_inv: assert property (p_load_bat2_inv)
		else $error("code 7 load output not inverse of charge request");

	property p_aux_alarm;
		@(posedge ref_clk) disable iff (!reset_n)
		(st_q.run && st_q.sel.aux == ofs_pkg::SEL_ALARM_ON)
			|-> (out_o.aux_out == $past(func_i.below_alarm));
	endproperty
	a_aux_alarm: assert property (p_aux_alarm)
		else $error("code 9 aux output not on below alarm");

	property p_aux_shunt_inv;
		@(posedge ref_clk) disable iff (!reset_n)
		(st_q.run && st_q.sel.aux == ofs_pkg::SEL_SHUNT_INV)
			|-> (out_o.aux_out == $past(func_i.shunt_disconnect));
	endproperty
	a_aux_shunt_inv: assert property (p_aux_shunt_inv)
		else $error("code 11 aux output wrong polarity");

	property p_load_unused;
		@(posedge ref_clk) disable iff (!reset_n)
		(st_q.run && st_q.sel.load > ofs_pkg::SEL_SHUNT_INV)
			|-> !out_o.load_out;
	endproperty
	a_load_unused: assert property (p_load_unused)
		else $error("unassigned code drives load output");

	property p_sel_hold;
		@(posedge ref_clk) disable iff (!reset_n)
		!load_select_wr |=> (st_q.sel.load == $past(st_q.sel.load));
	endproperty
	a_sel_hold: assert property (p_sel_hold)
		else $error("load selector changed without a write");

	property p_sel_write;
		@(posedge ref_clk) disable iff (!reset_n)
		aux_select_wr
			|=> (st_q.sel.aux == $past(aux_output_select));
	endproperty
	a_sel_write: assert property (p_sel_write)
		else $error("aux selector write not taken");

	property p_load_shunt_off;
		@(posedge ref_clk) disable iff (!reset_n)
		(sel_nx.load == ofs_pkg::SEL_SHUNT && func_i.shunt_disconnect)
			|=> !out_o.load_out;
	endproperty
	a_load_shunt_off: assert property (p_load_shunt_off)
		else $error("dump load kept on while shunt wants it off");

	property p_solar_series;
		@(posedge ref_clk) disable iff (!reset_n)
		(st_q.run && out_o.solar_input_switch)
			|-> $past(series_charge_on);
	endproperty
	a_solar_series: assert property (p_solar_series)
		else $error("solar switch on without series request");

endmodule : ofs_output_selector

`default_nettype wire

// ---- verif/ofs_term_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// far-side terminal: relay coil or dump load, counts switch-ons
module ofs_term_model (
	input wire logic ref_clk,
	input wire logic clr,
	input wire logic line,
	output logic [15:0] n_rise,
	output logic [15:0] n_high
);
	logic prev_q;

	always_ff @(posedge ref_clk) begin
		prev_q <= line;
		if (clr) begin
			n_rise <= 16'h0000;
			n_high <= 16'h0000;
		end else begin
			n_rise <= n_rise + {15'h0000, line & ~prev_q};
			n_high <= n_high + {15'h0000, line};
		end
	end
endmodule : ofs_term_model

`default_nettype wire

// ---- verif/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
	localparam int unsigned PER = 16;
	localparam int LIMIT = 5000;
	logic ref_clk, reset_n, lwr, awr, ser, psol, pload, clr;
	logic [3:0] lsel, asel;
	logic [20:0] sduty, hduty;
	logic [4:0] e;
	ofs_pkg::ofs_func_type func;
	ofs_pkg::ofs_sel_type sel;
	ofs_pkg::ofs_out_type out;
	logic [15:0] lr, lh, ar, ah, sr, sh;
	int n_errors = 0;
	int samples_checked = 0;
	int cyc = 0;

	ofs_output_selector #(.CNT_W(21), .PWM_PERIOD(PER)) u_dut (
		.ref_clk(ref_clk), .reset_n(reset_n),
		.load_output_select(lsel), .load_select_wr(lwr),
		.aux_output_select(asel), .aux_select_wr(awr),
		.func_i(func), .series_charge_on(ser),
		.pwm_solar_en(psol), .pwm_load_en(pload),
		.solar_duty(sduty), .shunt_duty(hduty),
		.sel_o(sel), .out_o(out));

	ofs_term_model u_load (.ref_clk(ref_clk), .clr(clr),
		.line(out.load_out), .n_rise(lr), .n_high(lh));
	ofs_term_model u_aux (.ref_clk(ref_clk), .clr(clr),
		.line(out.aux_out), .n_rise(ar), .n_high(ah));
	ofs_term_model u_sol (.ref_clk(ref_clk), .clr(clr),
		.line(out.solar_input_switch), .n_rise(sr), .n_high(sh));

	// ==========================================================
	// clock and timeout
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			n_errors++;
			print_verdict();
		end
	end

	// ==========================================================
	// helpers
	task automatic tick;
		@(posedge ref_clk);
		#1;
	endtask : tick

	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what,
				got, exp);
		end
	endtask : chk

	task automatic print_verdict;
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict

	// f: lbd, gen, event, batt2, alarm, shunt from msb down
	function automatic logic lvl(input logic [3:0] c, input logic [5:0] f);
		if (c > 4'hb) begin
			lvl = 1'b0;
		end else begin
			lvl = f[3'h5 - c[3:1]] ^ c[0] ^ c[3];
		end
	endfunction : lvl

	// ==========================================================
	// tests
	initial begin
		reset_n = 1'b0;
		{lwr, awr, ser, psol, pload, clr} = 6'h00;
		lsel = 4'h0;
		asel = 4'h0;
		func = '0;
		sduty = 21'h000000;
		hduty = 21'h000000;
		repeat (10) tick();
		chk({3'h0, out}, 8'h00, "reset out");
		chk(sel, 8'h12, "reset sel");
		reset_n = 1'b1;
		tick();
		chk({3'h0, out}, 8'h10, "first edge");
		lwr = 1'b1;
		awr = 1'b1;
		for (int i = 0; i < 2048; i++) begin
			lsel = i[3:0];
			asel = 4'hf - i[3:0];
			func = ofs_pkg::ofs_func_type'(i[9:4]);
			ser = i[10];
			tick();
			e = {lvl(lsel, func), lvl(asel, func), func[5], func[4], ser};
			chk({3'h0, out}, {3'h0, e}, "route");
			chk(sel, {lsel, asel}, "sel");
		end
		lwr = 1'b0;
		awr = 1'b0;
		lsel = 4'h3;
		tick();
		chk(sel, 8'hf0, "no write");
		// load pwm only ever paired with code 10
		lwr = 1'b1;
		awr = 1'b1;
		lsel = 4'ha;
		asel = 4'ha;
		func = '0;
		{pload, psol, ser} = 3'h7;
		sduty = 21'h000008;
		hduty = 21'h000004;
		tick();
		lwr = 1'b0;
		awr = 1'b0;
		repeat (2 * PER) tick();
		clr = 1'b1;
		tick();
		clr = 1'b0;
		repeat (10 * PER) tick();
		chk(lr[7:0], 8'h0a, "load pulses");
		chk(lh[7:0], 8'h28, "load high");
		chk(ar[7:0], 8'h00, "aux pulses");
		chk(ah[7:0], 8'ha0, "aux high");
		chk(sr[7:0], 8'h0a, "solar pulses");
		chk(sh[7:0], 8'h50, "solar high");
		func = ofs_pkg::ofs_func_type'(6'h01);
		repeat (2) tick();
		clr = 1'b1;
		tick();
		clr = 1'b0;
		repeat (PER) tick();
		chk(lh[7:0], 8'h00, "shunt off load");
		chk(ah[7:0], 8'h00, "shunt off aux");
		chk(sh[7:0], 8'h08, "solar kept");
		print_verdict();
	end
endmodule : tb

`default_nettype wire
